// file: logic/audio_input_path_defs.svh
`ifndef AUDIO_INPUT_PATH_DEFS_SVH
`define AUDIO_INPUT_PATH_DEFS_SVH

// Control word addresses
`define ADDR_LEFT_LINE      7'h00
`define ADDR_RIGHT_LINE     7'h01
`define ADDR_ANALOGUE_PATH  7'h04
`define ADDR_DIGITAL_PATH   7'h05

// Line input fields
`define GAIN_LSB            0
`define GAIN_MSB            4
`define LINE_MUTE_BIT       7
`define LINE_COPY_BIT       8

// Analogue path fields
`define MIC_BOOST_BIT       0
`define MIC_MUTE_BIT        1
`define SOURCE_SELECT_BIT   2

// Digital path fields
`define HPF_DISABLE_BIT     0
`define OFFSET_HOLD_BIT     4

// Reset values
`define GAIN_RESET          5'h17
`define LINE_MUTE_RESET     1'h1
`define LINE_COPY_RESET     1'h0
`define MIC_BOOST_RESET     1'h0
`define MIC_MUTE_RESET      1'h1
`define SOURCE_SELECT_RESET 1'h0
`define HPF_DISABLE_RESET   1'h0
`define OFFSET_HOLD_RESET   1'h0
`define MIC_BIAS_RESET      1'h0

// Record filter
`define SAMPLE_WIDTH        24
`define DECIM_LOG2          6
`define HPF_SHIFT           10

`endif

// file: logic/audio_input_path_pkg.sv
`default_nettype none
package audio_input_path_pkg;
  typedef logic signed [23:0] sample_type;
  typedef logic [4:0]         gain_type;
endpackage
`default_nettype wire

// file: logic/record_channel_filter.sv
`include "audio_input_path_defs.svh"
`default_nettype none
module record_channel_filter (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       in_valid,
  input  wire audio_input_path_pkg::sample_type in_sample,
  input  wire logic                       highpass_disable,
  input  wire logic                       offset_hold,
  output logic                            out_valid,
  output audio_input_path_pkg::sample_type out_sample
);

  localparam int ACC_W = `SAMPLE_WIDTH + `DECIM_LOG2;

  logic [`DECIM_LOG2-1:0]           count_reg;
  logic [`DECIM_LOG2-1:0]           count_next;
  logic signed [ACC_W-1:0]          acc_reg;
  logic signed [ACC_W-1:0]          acc_next;
  logic signed [ACC_W-1:0]          sum;
  audio_input_path_pkg::sample_type offset_reg;
  audio_input_path_pkg::sample_type offset_next;
  audio_input_path_pkg::sample_type out_reg;
  audio_input_path_pkg::sample_type out_next;
  audio_input_path_pkg::sample_type dec_sample;
  audio_input_path_pkg::sample_type applied;
  logic                             valid_reg;
  logic                             valid_next;
  logic                             clear_offset;
  logic signed [`SAMPLE_WIDTH:0]    diff;
  logic signed [`SAMPLE_WIDTH:0]    step;
  logic signed [`SAMPLE_WIDTH:0]    corrected;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    count_next   = count_reg;
    acc_next     = acc_reg;
    offset_next  = offset_reg;
    out_next     = out_reg;
    valid_next   = 1'b0;
    clear_offset = highpass_disable && !offset_hold;
    applied      = clear_offset ? '0 : offset_reg;
    sum          = acc_reg + ACC_W'(in_sample);
    dec_sample   = sum[ACC_W-1:`DECIM_LOG2];
    diff         = {dec_sample[`SAMPLE_WIDTH-1], dec_sample}
                 - {offset_reg[`SAMPLE_WIDTH-1], offset_reg};
    step         = diff >>> `HPF_SHIFT;
    corrected    = {dec_sample[`SAMPLE_WIDTH-1], dec_sample}
                 - {applied[`SAMPLE_WIDTH-1], applied};
    if (clear_offset) begin
      offset_next = '0;
    end
    if (in_valid) begin
      count_next = count_reg + 1'b1;
      if (count_reg == '1) begin
        acc_next   = '0;
        valid_next = 1'b1;
        if (corrected[`SAMPLE_WIDTH] != corrected[`SAMPLE_WIDTH-1]) begin
          out_next = {corrected[`SAMPLE_WIDTH], {(`SAMPLE_WIDTH-1){~corrected[`SAMPLE_WIDTH]}}};
        end else begin
          out_next = corrected[`SAMPLE_WIDTH-1:0];
        end
        if (!highpass_disable) begin
          offset_next = offset_reg + step[`SAMPLE_WIDTH-1:0];
        end
      end else begin
        acc_next = sum;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg  <= '0;
      acc_reg    <= '0;
      offset_reg <= '0;
      out_reg    <= '0;
      valid_reg  <= 1'b0;
    end else begin
      count_reg  <= count_next;
      acc_reg    <= acc_next;
      offset_reg <= offset_next;
      out_reg    <= out_next;
      valid_reg  <= valid_next;
    end
  end

  assign out_valid  = valid_reg;
  assign out_sample = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_offset_frozen;
    @(posedge clk) disable iff (!nrst)
    (highpass_disable && offset_hold) |-> (offset_next == offset_reg);
  endproperty
  a_offset_frozen: assert property (p_offset_frozen)
    else $error("held offset changed while filter disabled");

  property p_offset_cleared;
    @(posedge clk) disable iff (!nrst)
    (highpass_disable && !offset_hold) |-> (offset_next == '0);
  endproperty
  a_offset_cleared: assert property (p_offset_cleared)
    else $error("offset not cleared with hold off");

  property p_decimate;
    @(posedge clk) disable iff (!nrst)
    valid_reg |-> ($past(in_valid) && ($past(count_reg) == '1));
  endproperty
  a_decimate: assert property (p_decimate)
    else $error("output sample without full decimation block");

endmodule
`default_nettype wire

// file: logic/audio_input_path_control.sv
`include "audio_input_path_defs.svh"
`default_nettype none
module audio_input_path_control (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       ctrl_write,
  input  wire logic [6:0]                 ctrl_address,
  input  wire logic [8:0]                 ctrl_data,
  input  wire logic                       standby,
  input  wire logic                       sample_in_valid,
  input  wire audio_input_path_pkg::sample_type left_sample_in,
  input  wire audio_input_path_pkg::sample_type right_sample_in,
  output logic [4:0]                      left_line_gain,
  output logic                            left_line_mute,
  output logic                            left_to_right_gain_copy,
  output logic [4:0]                      right_line_gain,
  output logic                            right_line_mute,
  output logic                            right_to_left_gain_copy,
  output logic                            microphone_gain_boost,
  output logic                            microphone_record_mute,
  output logic                            record_source_select,
  output logic                            record_highpass_disable,
  output logic                            offset_hold_on_disable,
  output logic                            microphone_bias_output,
  output logic                            record_sample_valid,
  output audio_input_path_pkg::sample_type record_left_sample,
  output audio_input_path_pkg::sample_type record_right_sample
);

  audio_input_path_pkg::gain_type left_gain_reg;
  audio_input_path_pkg::gain_type left_gain_next;
  audio_input_path_pkg::gain_type right_gain_reg;
  audio_input_path_pkg::gain_type right_gain_next;
  logic                           left_mute_reg;
  logic                           left_mute_next;
  logic                           right_mute_reg;
  logic                           right_mute_next;
  logic                           l2r_copy_reg;
  logic                           l2r_copy_next;
  logic                           r2l_copy_reg;
  logic                           r2l_copy_next;
  logic                           boost_reg;
  logic                           boost_next;
  logic                           mic_mute_reg;
  logic                           mic_mute_next;
  logic                           source_reg;
  logic                           source_next;
  logic                           hpf_disable_reg;
  logic                           hpf_disable_next;
  logic                           hold_reg;
  logic                           hold_next;
  logic                           bias_reg;
  logic                           bias_next;
  logic                           left_write;
  logic                           right_write;

  ////////////////////////////////////////////////////////////////////////////
  // Control word decode; bits 6:5 of line words are simply never read
  always_comb begin
    left_gain_next   = left_gain_reg;
    right_gain_next  = right_gain_reg;
    left_mute_next   = left_mute_reg;
    right_mute_next  = right_mute_reg;
    l2r_copy_next    = l2r_copy_reg;
    r2l_copy_next    = r2l_copy_reg;
    boost_next       = boost_reg;
    mic_mute_next    = mic_mute_reg;
    source_next      = source_reg;
    hpf_disable_next = hpf_disable_reg;
    hold_next        = hold_reg;
    bias_next        = !standby;
    left_write       = ctrl_write && (ctrl_address == `ADDR_LEFT_LINE);
    right_write      = ctrl_write && (ctrl_address == `ADDR_RIGHT_LINE);
    if (ctrl_write) begin
      case (ctrl_address)
        `ADDR_LEFT_LINE: begin
          left_gain_next = ctrl_data[`GAIN_MSB:`GAIN_LSB];
          left_mute_next = ctrl_data[`LINE_MUTE_BIT];
          l2r_copy_next  = ctrl_data[`LINE_COPY_BIT];
          if (ctrl_data[`LINE_COPY_BIT]) begin
            right_gain_next = ctrl_data[`GAIN_MSB:`GAIN_LSB];
            right_mute_next = ctrl_data[`LINE_MUTE_BIT];
          end
        end
        `ADDR_RIGHT_LINE: begin
          right_gain_next = ctrl_data[`GAIN_MSB:`GAIN_LSB];
          right_mute_next = ctrl_data[`LINE_MUTE_BIT];
          r2l_copy_next   = ctrl_data[`LINE_COPY_BIT];
          if (ctrl_data[`LINE_COPY_BIT]) begin
            left_gain_next = ctrl_data[`GAIN_MSB:`GAIN_LSB];
            left_mute_next = ctrl_data[`LINE_MUTE_BIT];
          end
        end
        `ADDR_ANALOGUE_PATH: begin
          boost_next    = ctrl_data[`MIC_BOOST_BIT];
          mic_mute_next = ctrl_data[`MIC_MUTE_BIT];
          source_next   = ctrl_data[`SOURCE_SELECT_BIT];
        end
        `ADDR_DIGITAL_PATH: begin
          hpf_disable_next = ctrl_data[`HPF_DISABLE_BIT];
          hold_next        = ctrl_data[`OFFSET_HOLD_BIT];
        end
        default: begin
          bias_next = !standby;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_gain_reg   <= `GAIN_RESET;
      right_gain_reg  <= `GAIN_RESET;
      left_mute_reg   <= `LINE_MUTE_RESET;
      right_mute_reg  <= `LINE_MUTE_RESET;
      l2r_copy_reg    <= `LINE_COPY_RESET;
      r2l_copy_reg    <= `LINE_COPY_RESET;
      boost_reg       <= `MIC_BOOST_RESET;
      mic_mute_reg    <= `MIC_MUTE_RESET;
      source_reg      <= `SOURCE_SELECT_RESET;
      hpf_disable_reg <= `HPF_DISABLE_RESET;
      hold_reg        <= `OFFSET_HOLD_RESET;
      bias_reg        <= `MIC_BIAS_RESET;
    end else begin
      left_gain_reg   <= left_gain_next;
      right_gain_reg  <= right_gain_next;
      left_mute_reg   <= left_mute_next;
      right_mute_reg  <= right_mute_next;
      l2r_copy_reg    <= l2r_copy_next;
      r2l_copy_reg    <= r2l_copy_next;
      boost_reg       <= boost_next;
      mic_mute_reg    <= mic_mute_next;
      source_reg      <= source_next;
      hpf_disable_reg <= hpf_disable_next;
      hold_reg        <= hold_next;
      bias_reg        <= bias_next;
    end
  end

  assign left_line_gain          = left_gain_reg;
  assign left_line_mute          = left_mute_reg;
  assign left_to_right_gain_copy = l2r_copy_reg;
  assign right_line_gain         = right_gain_reg;
  assign right_line_mute         = right_mute_reg;
  assign right_to_left_gain_copy = r2l_copy_reg;
  assign microphone_gain_boost   = boost_reg;
  assign microphone_record_mute  = mic_mute_reg;
  assign record_source_select    = source_reg;
  assign record_highpass_disable = hpf_disable_reg;
  assign offset_hold_on_disable  = hold_reg;
  assign microphone_bias_output  = bias_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Record filters, one per channel
  audio_input_path_pkg::sample_type chan_in [2];
  audio_input_path_pkg::sample_type chan_out [2];
  logic                             chan_valid [2];

  assign chan_in[0]          = left_sample_in;
  assign chan_in[1]          = right_sample_in;
  assign record_left_sample  = chan_out[0];
  assign record_right_sample = chan_out[1];
  assign record_sample_valid = chan_valid[0];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      record_channel_filter u_filter (
        .clk              (clk),
        .nrst             (nrst),
        .in_valid         (sample_in_valid),
        .in_sample        (chan_in[ch]),
        .highpass_disable (hpf_disable_reg),
        .offset_hold      (hold_reg),
        .out_valid        (chan_valid[ch]),
        .out_sample       (chan_out[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  property p_left_copies_right;
    @(posedge clk) disable iff (!nrst)
    (left_write && ctrl_data[`LINE_COPY_BIT]) |=>
      (right_gain_reg == $past(ctrl_data[4:0])) && (right_mute_reg == $past(ctrl_data[7]));
  endproperty
  a_left_copies_right: assert property (p_left_copies_right)
    else $error("left write with copy did not load right channel");

  property p_right_copies_left;
    @(posedge clk) disable iff (!nrst)
    (right_write && ctrl_data[`LINE_COPY_BIT]) |=>
      (left_gain_reg == $past(ctrl_data[4:0])) && (left_mute_reg == $past(ctrl_data[7]));
  endproperty
  a_right_copies_left: assert property (p_right_copies_left)
    else $error("right write with copy did not load left channel");

  property p_no_copy_keeps_right;
    @(posedge clk) disable iff (!nrst)
    (left_write && !ctrl_data[`LINE_COPY_BIT]) |=>
      $stable(right_gain_reg) && $stable(right_mute_reg) && (left_mute_reg == $past(ctrl_data[7]));
  endproperty
  a_no_copy_keeps_right: assert property (p_no_copy_keeps_right)
    else $error("left write without copy disturbed right channel");

  property p_gain_stable_without_write;
    @(posedge clk) disable iff (!nrst)
    (!left_write && !right_write) |=> $stable(left_gain_reg) && $stable(right_gain_reg);
  endproperty
  a_gain_stable_without_write: assert property (p_gain_stable_without_write)
    else $error("line gain changed without a line write");

  property p_right_gain_load;
    @(posedge clk) disable iff (!nrst)
    right_write |=> (right_gain_reg == $past(ctrl_data[4:0])) && (right_mute_reg == $past(ctrl_data[7]));
  endproperty
  a_right_gain_load: assert property (p_right_gain_load)
    else $error("right line write not loaded");

  property p_analogue_load;
    @(posedge clk) disable iff (!nrst)
    (ctrl_write && ctrl_address == `ADDR_ANALOGUE_PATH) |=>
      ({source_reg, mic_mute_reg, boost_reg} == $past(ctrl_data[2:0]));
  endproperty
  a_analogue_load: assert property (p_analogue_load)
    else $error("analogue path fields not loaded");

  property p_digital_load;
    @(posedge clk) disable iff (!nrst)
    (ctrl_write && ctrl_address == `ADDR_DIGITAL_PATH) |=>
      (hpf_disable_reg == $past(ctrl_data[0])) && (hold_reg == $past(ctrl_data[4]));
  endproperty
  a_digital_load: assert property (p_digital_load)
    else $error("digital path fields not loaded");

  property p_bias_off_in_standby;
    @(posedge clk) disable iff (!nrst)
    standby |=> !microphone_bias_output;
  endproperty
  a_bias_off_in_standby: assert property (p_bias_off_in_standby)
    else $error("microphone bias active in standby");

  property p_channels_aligned;
    @(posedge clk) disable iff (!nrst)
    chan_valid[0] == chan_valid[1];
  endproperty
  a_channels_aligned: assert property (p_channels_aligned)
    else $error("record channels out of step");

endmodule
`default_nettype wire

// file: dv/testbench.sv
`include "audio_input_path_defs.svh"
`default_nettype none
`define TB_CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("mismatch at %0t got %h expected %h", $time, got, exp); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                             clk, nrst, ctrl_write, standby, sample_in_valid;
  logic [6:0]                       ctrl_address;
  logic [8:0]                       ctrl_data;
  audio_input_path_pkg::sample_type left_sample_in, right_sample_in;
  audio_input_path_pkg::sample_type record_left_sample, record_right_sample;
  logic [4:0]                       left_line_gain, right_line_gain;
  logic                             left_line_mute, left_to_right_gain_copy;
  logic                             right_line_mute, right_to_left_gain_copy;
  logic                             microphone_gain_boost, microphone_record_mute;
  logic                             record_source_select, record_highpass_disable;
  logic                             offset_hold_on_disable, microphone_bias_output;
  logic                             record_sample_valid;
  logic [4:0]                       m_lg, m_rg;
  logic                             m_lm, m_lc, m_rm, m_rc, m_bo, m_mm, m_sel, m_hpd, m_hold;
  longint                           off_l, off_r;
  logic [15:0]                      wq[$];
  logic                             sb_old;
  int                               err_total, check_count, cyc_count;

  audio_input_path_control uut (
    .clk, .nrst, .ctrl_write, .ctrl_address, .ctrl_data, .standby, .sample_in_valid,
    .left_sample_in, .right_sample_in, .left_line_gain, .left_line_mute,
    .left_to_right_gain_copy, .right_line_gain, .right_line_mute,
    .right_to_left_gain_copy, .microphone_gain_boost, .microphone_record_mute,
    .record_source_select, .record_highpass_disable, .offset_hold_on_disable,
    .microphone_bias_output, .record_sample_valid, .record_left_sample,
    .record_right_sample
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 30000) begin
      err_total++;
      report_and_stop();
    end
  end

  task report_and_stop();
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Expected register state after one taken word
  task automatic apply(input logic [6:0] a, input logic [8:0] d);
    case (a)
      `ADDR_LEFT_LINE: begin
        m_lg = d[4:0];
        m_lm = d[7];
        m_lc = d[8];
        if (d[8]) begin
          m_rg = d[4:0];
          m_rm = d[7];
        end
      end
      `ADDR_RIGHT_LINE: begin
        m_rg = d[4:0];
        m_rm = d[7];
        m_rc = d[8];
        if (d[8]) begin
          m_lg = d[4:0];
          m_lm = d[7];
        end
      end
      `ADDR_ANALOGUE_PATH: begin
        m_bo = d[0];
        m_mm = d[1];
        m_sel = d[2];
      end
      `ADDR_DIGITAL_PATH: begin
        m_hpd = d[0];
        m_hold = d[4];
      end
      default: ;
    endcase
    if (m_hpd && !m_hold) begin
      off_l = 0;
      off_r = 0;
    end
  endtask

  task automatic check_regs();
    `TB_CHK(left_line_gain, m_lg)
    `TB_CHK(left_line_mute, m_lm)
    `TB_CHK(left_to_right_gain_copy, m_lc)
    `TB_CHK(right_line_gain, m_rg)
    `TB_CHK(right_line_mute, m_rm)
    `TB_CHK(right_to_left_gain_copy, m_rc)
    `TB_CHK(microphone_gain_boost, m_bo)
    `TB_CHK(microphone_record_mute, m_mm)
    `TB_CHK(record_source_select, m_sel)
    `TB_CHK(record_highpass_disable, m_hpd)
    `TB_CHK(offset_hold_on_disable, m_hold)
  endtask

  // Back-to-back control words, each checked just after the edge that takes it
  task automatic flush();
    for (int i = 0; i <= wq.size(); i++) begin
      @(posedge clk);
      if (i < wq.size()) begin
        ctrl_write <= 1'b1;
        ctrl_address <= wq[i][15:9];
        ctrl_data <= wq[i][8:0];
      end else ctrl_write <= 1'b0;
      #1;
      if (i > 0) begin
        apply(wq[i-1][15:9], wq[i-1][8:0]);
        check_regs();
      end
    end
    wq.delete();
  endtask

  task automatic filt(input longint avg, inout longint off, output longint res);
    res = avg - off;
    if (!m_hpd) off = off + ((avg - off) >>> 10);
  endtask

  task automatic run_block(input longint dc);
    longint sl, sr, l, r, el, er;
    int     w;
    sl = 0;
    sr = 0;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      l = dc + longint'($urandom_range(4095)) - 2048;
      r = -dc + longint'($urandom_range(4095)) - 2048;
      sample_in_valid <= 1'b1;
      left_sample_in <= l[23:0];
      right_sample_in <= r[23:0];
      sl += l;
      sr += r;
    end
    @(posedge clk);
    sample_in_valid <= 1'b0;
    #1;
    w = 0;
    while (record_sample_valid !== 1'b1 && w < 4) begin
      @(posedge clk);
      #1;
      w++;
    end
    filt(sl >>> 6, off_l, el);
    filt(sr >>> 6, off_r, er);
    `TB_CHK(record_sample_valid, 1'b1)
    `TB_CHK(record_left_sample, el[23:0])
    `TB_CHK(record_right_sample, er[23:0])
    @(posedge clk);
    #1;
    `TB_CHK(record_sample_valid, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [6:0] tbl[4];
    logic [6:0] a;
    void'($urandom(69));
    tbl = '{`ADDR_LEFT_LINE, `ADDR_RIGHT_LINE, `ADDR_ANALOGUE_PATH, `ADDR_DIGITAL_PATH};
    {nrst, ctrl_write, standby, sample_in_valid} = 4'h0;
    // Idle bus and sample inputs carry noise until first use
    ctrl_address = 7'($urandom);
    ctrl_data = 9'($urandom);
    left_sample_in = 24'($urandom);
    right_sample_in = 24'($urandom);
    {err_total, check_count, cyc_count} = '0;
    {m_lg, m_rg} = {`GAIN_RESET, `GAIN_RESET};
    {m_lm, m_rm, m_lc, m_rc} = 4'hC;
    {m_bo, m_mm, m_sel, m_hpd, m_hold} = 5'h08;
    off_l = 0;
    off_r = 0;
    repeat (7) @(posedge clk);
    #1;
    `TB_CHK(microphone_bias_output, 1'b0)
    @(posedge clk);
    nrst <= 1'b1;
    #1;
    check_regs();
    wq = '{16'h0197, 16'h0260, 16'h0300, 16'h04FF, 16'h0A1F, 16'h0800, 16'h0B11};
    wq.push_back(16'h0A00);
    wq.push_back(16'hFFFF);
    wq.push_back(16'h0500);
    flush();
    for (int i = 0; i < 60; i++) begin
      a = ($urandom_range(4) == 4) ? 7'($urandom) : tbl[$urandom_range(3)];
      wq.push_back({a, 9'($urandom)});
    end
    flush();
    sb_old = 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      standby <= 1'($urandom);
      #1;
      `TB_CHK(microphone_bias_output, ~sb_old)
      sb_old = standby;
    end
    wq.push_back(16'h0A00);
    flush();
    repeat (5) run_block(300000);
    wq.push_back(16'h0A11);
    flush();
    repeat (2) run_block(-100000);
    wq.push_back(16'h0A00);
    flush();
    repeat (2) run_block(200000);
    wq.push_back(16'h0A01);
    flush();
    run_block(50000);
    report_and_stop();
  end
endmodule
`undef TB_CHK
`default_nettype wire
